// ---- eac_pkg.sv ----
package eac_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] NVM_CONTROL_OFS = 6'h1c;
  localparam logic [5:0] NVM_DATA_OFS = 6'h1d;
  localparam logic [5:0] NVM_ADDRESS_LOW_OFS = 6'h1e;
  localparam logic [5:0] NVM_ADDRESS_HIGH_OFS = 6'h1f;

  // ****************************************
  // Control field positions
  // ****************************************
  localparam int READ_STROBE_POS = 0;
  localparam int PROGRAM_TRIGGER_POS = 1;
  localparam int PROGRAM_ARM_POS = 2;
  localparam int READY_IRQ_ENABLE_POS = 3;
  localparam int PROGRAM_ACTION_LO_POS = 4;
  localparam int PROGRAM_ACTION_HI_POS = 5;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int ADDR_W = 9;
  localparam int NVM_DEPTH = 512;
  localparam logic [7:0] BYTE_VALUE_RST = 8'h00;
  localparam logic [1:0] ACTION_RST = 2'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int ARM_WINDOW_CYCLES = 4;
  localparam int STALL_PROGRAM_CYCLES = 2;
  localparam int STALL_READ_CYCLES = 4;
  localparam int OSC_TICK_NS = 1000;
  localparam int OSC_TICK_CYCLES = OSC_TICK_NS / CLK_PERIOD_NS;
  localparam real T_ATOMIC_MS = 3.4;
  localparam real T_SPLIT_MS = 1.8;
  localparam int ATOMIC_TICKS = int'(T_ATOMIC_MS * 1.0e6 / OSC_TICK_NS);
  localparam int SPLIT_TICKS = int'(T_SPLIT_MS * 1.0e6 / OSC_TICK_NS);
  localparam int TICK_CNT_W = 16;

  // ****************************************
  // Programming actions
  // ****************************************
  typedef enum logic [1:0] {
    ACT_ERASE_WRITE,
    ACT_ERASE_ONLY,
    ACT_WRITE_ONLY,
    ACT_RESERVED
  } eac_action_type;

endpackage : eac_pkg

// ---- eac_prog_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

module eac_prog_timer #(
  parameter int TICK_CYCLES = eac_pkg::OSC_TICK_CYCLES,
  parameter int CNT_W = eac_pkg::TICK_CNT_W
) (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic por_i,
  // Start
  input wire logic start_i,
  input wire logic [CNT_W-1:0] ticks_i,
  // Status
  output logic busy_o,
  output logic done_o
);
  import eac_pkg::*;

  typedef struct packed {
    logic [15:0] pre;
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } eac_timer_type;

  eac_timer_type st_r;
  eac_timer_type st_nxt;

  // ****************************************
  // Oscillator tick divider and down-counter
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start_i && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = ticks_i;
      st_nxt.pre = 16'(TICK_CYCLES - 1);
    end else if (st_r.busy) begin
      if (st_r.pre == 16'h0000) begin
        st_nxt.pre = 16'(TICK_CYCLES - 1);
        if (st_r.cnt <= CNT_W'(1)) begin
          st_nxt.cnt = '0;
          st_nxt.busy = 1'b0;
          st_nxt.done = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
        end
      end else begin
        st_nxt.pre = st_r.pre - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge por_i) begin
    if (por_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
  assign done_o = st_r.done;

endmodule : eac_prog_timer

`default_nettype wire

// ---- eac_byte_array.sv ----
`timescale 1ns/10ps
`default_nettype none

module eac_byte_array #(
  parameter int DEPTH = eac_pkg::NVM_DEPTH,
  parameter int AW = eac_pkg::ADDR_W
) (
  // Clock
  input wire logic clk_i,
  // Program port
  input wire logic commit_i,
  input wire logic [1:0] action_i,
  input wire logic [AW-1:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  // Read port
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  import eac_pkg::*;

  logic [7:0] mem [DEPTH];

  // ****************************************
  // Nonvolatile storage, no reset
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (commit_i) begin
      case (eac_action_type'(action_i))
        ACT_ERASE_WRITE: mem[prog_addr_i] <= prog_data_i;
        ACT_ERASE_ONLY: mem[prog_addr_i] <= ERASED_BYTE;
        ACT_WRITE_ONLY: mem[prog_addr_i] <= mem[prog_addr_i] & prog_data_i;
        default: mem[prog_addr_i] <= mem[prog_addr_i];
      endcase
    end
  end

  assign rd_data_o = mem[rd_addr_i];

endmodule : eac_byte_array

`default_nettype wire

// ---- eac_access_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none

module eac_access_ctrl #(
  parameter int ATOMIC_TICKS = eac_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS = eac_pkg::SPLIT_TICKS,
  parameter int TICK_CYCLES = eac_pkg::OSC_TICK_CYCLES
) (
  // Clock and resets
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic POR_I,
  // I/O register port
  input wire logic [5:0] IO_ADDR_I,
  input wire logic IO_WE_I,
  input wire logic IO_RE_I,
  input wire logic [7:0] IO_WDATA_I,
  output logic [7:0] IO_RDATA_O,
  // Core interface
  input wire logic GIE_I,
  output logic STALL_O,
  output logic IRQ_O
);
  import eac_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] byte_address;
    logic [7:0] byte_value;
    logic ready_irq_enable;
    logic program_arm;
    logic [2:0] arm_cnt;
    logic stall;
    logic [2:0] stall_cnt;
    logic [7:0] rdata;
    logic irq;
  } eac_sys_type;

  typedef struct packed {
    logic [1:0] program_action_select;
    logic [1:0] op_action;
    logic [ADDR_W-1:0] op_addr;
    logic [7:0] op_data;
  } eac_eng_type;

  eac_sys_type sys_r;
  eac_sys_type sys_nxt;
  eac_eng_type eng_r;
  eac_eng_type eng_nxt;

  logic busy;
  logic done;
  logic start;
  logic [TICK_CNT_W-1:0] start_ticks;
  logic [7:0] fetched;
  logic [1:0] act_sel;
  logic wr_ctrl;
  logic trig_req;
  logic read_req;

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    wr_ctrl = IO_WE_I && (IO_ADDR_I == NVM_CONTROL_OFS);
    act_sel = eng_r.program_action_select;
    if (wr_ctrl && !busy) begin
      act_sel = IO_WDATA_I[PROGRAM_ACTION_HI_POS:PROGRAM_ACTION_LO_POS];
    end
    if (RST_I && !busy) begin
      act_sel = ACTION_RST;
    end
    trig_req = wr_ctrl && IO_WDATA_I[PROGRAM_TRIGGER_POS];
    start = trig_req && sys_r.program_arm && !busy
      && (eac_action_type'(act_sel) != ACT_RESERVED);
    read_req = wr_ctrl && IO_WDATA_I[READ_STROBE_POS] && !busy && !start;
    if (eac_action_type'(act_sel) == ACT_ERASE_WRITE) begin
      start_ticks = TICK_CNT_W'(ATOMIC_TICKS);
    end else begin
      start_ticks = TICK_CNT_W'(SPLIT_TICKS);
    end
  end

  // ****************************************
  // Programming engine, power-on reset; RST_I also clears the action select while not busy
  // ****************************************
  always_comb begin
    eng_nxt = eng_r;
    eng_nxt.program_action_select = act_sel;
    if (start) begin
      eng_nxt.op_action = act_sel;
      eng_nxt.op_addr = sys_r.byte_address;
      eng_nxt.op_data = sys_r.byte_value;
    end
  end

  always_ff @(posedge CLK_I or posedge POR_I) begin
    if (POR_I) begin
      eng_r <= '0;
    end else begin
      eng_r <= eng_nxt;
    end
  end

  eac_prog_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .CNT_W(TICK_CNT_W)
  ) u_timer (
    .clk_i(CLK_I),
    .por_i(POR_I),
    .start_i(start),
    .ticks_i(start_ticks),
    .busy_o(busy),
    .done_o(done)
  );

  eac_byte_array #(
    .DEPTH(NVM_DEPTH),
    .AW(ADDR_W)
  ) u_array (
    .clk_i(CLK_I),
    .commit_i(done),
    .action_i(eng_r.op_action),
    .prog_addr_i(eng_r.op_addr),
    .prog_data_i(eng_r.op_data),
    .rd_addr_i(sys_r.byte_address),
    .rd_data_o(fetched)
  );

  // ****************************************
  // Register file and core handshake
  // ****************************************
  always_comb begin
    sys_nxt = sys_r;
    if (sys_r.program_arm) begin
      if (sys_r.arm_cnt == 3'h0) begin
        sys_nxt.program_arm = 1'b0;
      end else begin
        sys_nxt.arm_cnt = sys_r.arm_cnt - 3'h1;
      end
    end
    if (sys_r.stall) begin
      if (sys_r.stall_cnt == 3'h0) begin
        sys_nxt.stall = 1'b0;
      end else begin
        sys_nxt.stall_cnt = sys_r.stall_cnt - 3'h1;
      end
    end
    if (IO_WE_I) begin
      case (IO_ADDR_I)
        NVM_CONTROL_OFS: begin
          sys_nxt.ready_irq_enable = IO_WDATA_I[READY_IRQ_ENABLE_POS];
          if (IO_WDATA_I[PROGRAM_ARM_POS]) begin
            sys_nxt.program_arm = 1'b1;
            sys_nxt.arm_cnt = 3'(ARM_WINDOW_CYCLES - 1);
          end
        end
        NVM_DATA_OFS: sys_nxt.byte_value = IO_WDATA_I;
        NVM_ADDRESS_LOW_OFS: begin
          if (!busy) begin
            sys_nxt.byte_address[7:0] = IO_WDATA_I;
          end
        end
        NVM_ADDRESS_HIGH_OFS: begin
          if (!busy) begin
            sys_nxt.byte_address[8] = IO_WDATA_I[0];
          end
        end
        default: sys_nxt.byte_value = sys_nxt.byte_value;
      endcase
    end
    if (start) begin
      sys_nxt.stall = 1'b1;
      sys_nxt.stall_cnt = 3'(STALL_PROGRAM_CYCLES - 1);
    end
    if (read_req) begin
      sys_nxt.byte_value = fetched;
      sys_nxt.stall = 1'b1;
      sys_nxt.stall_cnt = 3'(STALL_READ_CYCLES - 1);
    end
    sys_nxt.irq = sys_nxt.ready_irq_enable && GIE_I && !busy && !start;
    if (IO_RE_I) begin
      case (IO_ADDR_I)
        NVM_CONTROL_OFS: begin
          sys_nxt.rdata = {2'b00, eng_r.program_action_select, sys_r.ready_irq_enable,
            sys_r.program_arm, busy, 1'b0};
        end
        NVM_DATA_OFS: sys_nxt.rdata = sys_r.byte_value;
        NVM_ADDRESS_LOW_OFS: sys_nxt.rdata = sys_r.byte_address[7:0];
        NVM_ADDRESS_HIGH_OFS: sys_nxt.rdata = {7'h00, sys_r.byte_address[8]};
        default: sys_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sys_r <= '0;
      sys_r.byte_value <= BYTE_VALUE_RST;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign IO_RDATA_O = sys_r.rdata;
  assign STALL_O = sys_r.stall;
  assign IRQ_O = sys_r.irq;

  // ****************************************
  // Assertions
  // ****************************************
  logic [5:0] busy_age;
  always_ff @(posedge CLK_I or posedge POR_I) begin
    if (POR_I) begin
      busy_age <= 6'h00;
    end else if (!busy) begin
      busy_age <= 6'h00;
    end else if (busy_age != 6'h3f) begin
      busy_age <= busy_age + 6'h01;
    end
  end

  property p_arm_clear;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    (wr_ctrl && IO_WDATA_I[PROGRAM_ARM_POS]) ##1 !(wr_ctrl && IO_WDATA_I[PROGRAM_ARM_POS]) [*4]
      |=> !sys_r.program_arm;
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm bit not cleared after four cycles");

  property p_arm_held;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    (wr_ctrl && IO_WDATA_I[PROGRAM_ARM_POS]) |=> sys_r.program_arm [*4];
  endproperty
  a_arm_held: assert property (p_arm_held) else $error("arm bit dropped early");

  property p_prog_stall;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    start |=> STALL_O ##1 STALL_O ##1 !STALL_O;
  endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("programming stall not two cycles");

  property p_read_stall;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    read_req |=> STALL_O [*4] ##1 !STALL_O;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

  property p_read_data;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    read_req |=> sys_r.byte_value == $past(fetched);
  endproperty
  a_read_data: assert property (p_read_data) else $error("fetched byte not in data register");

  property p_addr_frozen;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    (busy && !start) |=> $stable(sys_r.byte_address);
  endproperty
  a_addr_frozen: assert property (p_addr_frozen) else $error("address changed while busy");

  property p_mode_frozen;
    @(posedge CLK_I) disable iff (POR_I)
    busy |=> $stable(eng_r.program_action_select);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen) else $error("action field changed while busy");

  property p_no_arm_no_start;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    (trig_req && !sys_r.program_arm && !busy) |=> !busy;
  endproperty
  a_no_arm_no_start: assert property (p_no_arm_no_start) else $error("trigger acted without arm");

  property p_irq_level;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    (busy_age == 6'h3f) |-> !IRQ_O;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready interrupt while busy");

  property p_ctrl_top_zero;
    @(posedge CLK_I) disable iff (RST_I || POR_I)
    (IO_RE_I && IO_ADDR_I == NVM_CONTROL_OFS) |=> IO_RDATA_O[7:6] == 2'b00 && IO_RDATA_O[1] == $past(busy);
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control readback wrong");

endmodule : eac_access_ctrl

`default_nettype wire

// ---- eac_access_ctrl_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module eac_access_ctrl_tb_top;
  import eac_pkg::*;

  // ****************************************
  // Bench signals
  // ****************************************
  localparam int AT = 20;
  localparam int ST = 10;
  localparam int TC = 2;
  logic clk = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic gie = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic stall;
  logic irq;
  int fail_count = 0;
  int n_tests = 0;
  time t0 = 0;

  always #5 clk = ~clk;

  eac_access_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST), .TICK_CYCLES(TC)) DUT (
    .CLK_I(clk), .RST_I(rst_i), .POR_I(por_i),
    .IO_ADDR_I(adr), .IO_WE_I(we), .IO_RE_I(re), .IO_WDATA_I(wd), .IO_RDATA_O(rdata),
    .GIE_I(gie), .STALL_O(stall), .IRQ_O(irq)
  );

  // ****************************************
  // Reporting
  // ****************************************
  task stop_test;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task chkn(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chkn

  // ****************************************
  // Register bus tasks
  // ****************************************
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr

  task rd(input logic [5:0] a, output logic [7:0] q);
    @(posedge clk);
    adr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 q = rdata;
  endtask : rd

  task stalls(output int n);
    n = 0;
    repeat (8) begin
      #1;
      if (stall === 1'b1) n++;
      @(posedge clk);
    end
  endtask : stalls

  task setaddr(input logic [8:0] a);
    wr(NVM_ADDRESS_HIGH_OFS, {7'h00, a[8]});
    wr(NVM_ADDRESS_LOW_OFS, a[7:0]);
  endtask : setaddr

  task prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] act, output int n);
    setaddr(a);
    wr(NVM_DATA_OFS, d);
    wr(NVM_CONTROL_OFS, {2'b00, act, 4'h4});
    wr(NVM_CONTROL_OFS, {2'b00, act, 4'h2});
    t0 = $time;
    stalls(n);
  endtask : prog

  task wait_idle(input int cyc);
    logic [7:0] q;
    int i;
    i = 0;
    q = 8'h02;
    while (q[1] !== 1'b0 && i < 200) begin
      rd(NVM_CONTROL_OFS, q);
      i++;
    end
    chkn("busy time", cyc - 2, cyc + 6, int'(($time - t0) / 10));
  endtask : wait_idle

  task chk_byte(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] q;
    int n;
    setaddr(a);
    wr(NVM_CONTROL_OFS, 8'h01);
    stalls(n);
    chkn("read stall", STALL_READ_CYCLES, STALL_READ_CYCLES, n);
    rd(NVM_DATA_OFS, q);
    chk8("byte", e, q);
  endtask : chk_byte

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [7:0] q;
    rd(NVM_CONTROL_OFS, q);
    chk8("ctrl reset", 8'h00, q);
    rd(NVM_DATA_OFS, q);
    chk8("data reset", BYTE_VALUE_RST, q);
    wr(NVM_ADDRESS_HIGH_OFS, 8'hff);
    rd(NVM_ADDRESS_HIGH_OFS, q);
    chk8("addr high", 8'h01, q);
    wr(NVM_CONTROL_OFS, 8'hc0);
    rd(NVM_CONTROL_OFS, q);
    chk8("ctrl top", 8'h00, q);
    rd(6'h05, q);
    chk8("unmapped", 8'h00, q);
  endtask : t_reset

  task t_atomic;
    int n;
    prog(9'h1ff, 8'h3c, 2'b00, n);
    chkn("prog stall", STALL_PROGRAM_CYCLES, STALL_PROGRAM_CYCLES, n);
    wait_idle(AT * TC);
    prog(9'h0ff, 8'hc3, 2'b00, n);
    wait_idle(AT * TC);
    chk_byte(9'h1ff, 8'h3c);
    chk_byte(9'h0ff, 8'hc3);
  endtask : t_atomic

  task t_split;
    int n;
    prog(9'h1ab, 8'h00, 2'b01, n);
    wait_idle(ST * TC);
    chk_byte(9'h1ab, ERASED_BYTE);
    prog(9'h1ab, 8'h96, 2'b10, n);
    wait_idle(ST * TC);
    prog(9'h1ab, 8'h0f, 2'b10, n);
    wait_idle(ST * TC);
    chk_byte(9'h1ab, 8'h06);
    prog(9'h1ab, 8'h55, 2'b11, n);
    chkn("reserved stall", 0, 0, n);
    chk_byte(9'h1ab, 8'h06);
  endtask : t_split

  task t_arm;
    logic [7:0] q;
    int n;
    wr(NVM_CONTROL_OFS, 8'h04);
    rd(NVM_CONTROL_OFS, q);
    chk8("arm set", 8'h04, q);
    @(posedge clk);
    rd(NVM_CONTROL_OFS, q);
    chk8("arm cleared", 8'h00, q);
    wr(NVM_CONTROL_OFS, 8'h02);
    stalls(n);
    chkn("late trigger", 0, 0, n);
    rd(NVM_CONTROL_OFS, q);
    chk8("late idle", 8'h00, q);
    wr(NVM_CONTROL_OFS, 8'h04);
    repeat (2) @(posedge clk);
    wr(NVM_CONTROL_OFS, 8'h02);
    t0 = $time;
    stalls(n);
    chkn("edge trigger", STALL_PROGRAM_CYCLES, STALL_PROGRAM_CYCLES, n);
    wait_idle(AT * TC);
  endtask : t_arm

  task t_refuse;
    logic [7:0] q;
    int n;
    prog(9'h010, 8'h11, 2'b00, n);
    wr(NVM_ADDRESS_LOW_OFS, 8'h20);
    wr(NVM_CONTROL_OFS, 8'h12);
    wr(NVM_CONTROL_OFS, 8'h03);
    stalls(n);
    chkn("refused read", 0, 0, n);
    rd(NVM_ADDRESS_LOW_OFS, q);
    chk8("addr kept", 8'h10, q);
    rd(NVM_CONTROL_OFS, q);
    chk8("action kept", 8'h02, q);
    rd(NVM_DATA_OFS, q);
    chk8("data kept", 8'h11, q);
    wait_idle(AT * TC);
    chk_byte(9'h010, 8'h11);
  endtask : t_refuse

  task t_irq;
    @(posedge clk);
    gie <= 1'b1;
    wr(NVM_CONTROL_OFS, 8'h08);
    repeat (3) @(posedge clk);
    #1 chk8("irq ready", 8'h01, {7'h00, irq});
    wr(NVM_CONTROL_OFS, 8'h0c);
    wr(NVM_CONTROL_OFS, 8'h0a);
    t0 = $time;
    repeat (3) @(posedge clk);
    #1 chk8("irq busy", 8'h00, {7'h00, irq});
    wait_idle(AT * TC);
    repeat (3) @(posedge clk);
    #1 chk8("irq again", 8'h01, {7'h00, irq});
    @(posedge clk);
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk8("irq global off", 8'h00, {7'h00, irq});
    @(posedge clk);
    gie <= 1'b1;
    wr(NVM_CONTROL_OFS, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk8("irq disabled", 8'h00, {7'h00, irq});
  endtask : t_irq

  task t_rst_busy;
    logic [7:0] q;
    int n;
    prog(9'h020, 8'h77, 2'b10, n);
    @(posedge clk);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk);
    rst_i <= 1'b0;
    rd(NVM_CONTROL_OFS, q);
    chk8("busy over reset", 8'h22, q);
    wait_idle(ST * TC);
    @(posedge clk);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk);
    rst_i <= 1'b0;
    rd(NVM_CONTROL_OFS, q);
    chk8("action reset", 8'h00, q);
  endtask : t_rst_busy

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_reset;
    t_atomic;
    t_split;
    t_arm;
    t_refuse;
    t_irq;
    t_rst_busy;
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[FAIL] watchdog expected end seen hang");
    stop_test;
  end

endmodule : eac_access_ctrl_tb_top

`default_nettype wire
